/* File: hw/aops_pkg.sv */
// -----------------------------------------------------------------
// Shared constants for the output port sequencer
// -----------------------------------------------------------------
package aops_pkg;

  // Converter data width and number of converter channels
  localparam int DATA_W = 8;
  localparam int NUM_CH = 3;

  // Pipeline latencies, in conversion clock rising edges
  localparam int LAT_SINGLE = 4;
  localparam int LAT_DUAL = 5;
  localparam int LAT_PAR_A = 6;

  // Deepest stage needed is the port A latency of parallel format
  localparam int PIPE_DEPTH = LAT_PAR_A;

  // Stage index whose content is due at the output on this edge
  localparam int IDX_SINGLE = LAT_SINGLE - 1;
  localparam int IDX_DUAL = LAT_DUAL - 1;
  localparam int IDX_PAR_A = LAT_PAR_A - 1;

  // Port tag carried with each sample
  localparam logic TAG_PORT_A = 1'b0;
  localparam logic TAG_PORT_B = 1'b1;

  // Reset values
  localparam logic DCLK_RST = 1'b0;
  localparam logic RESTART_RST = 1'b1;

  // Status word crossed to the system clock: frozen, single, toggle
  localparam int STAT_W = 3;
  localparam int STAT_FROZEN = 0;
  localparam int STAT_SINGLE = 1;
  localparam int STAT_TOGGLE = 2;

  // Mode pins crossed into the conversion clock domain
  localparam int MODE_PIN_W = 2;
  localparam int PIN_OMS = 1;
  localparam int PIN_ILV = 0;

  // Output modes
  typedef enum logic [1:0] {
    MODE_PARALLEL,
    MODE_INTERLEAVED,
    MODE_SINGLE
  } aops_mode_e;

endpackage

/* File: hw/aops_bit_sync.sv */
`timescale 1ns/1ns
// -----------------------------------------------------------------
// Two flip-flop level synchroniser, one per bit
// -----------------------------------------------------------------
module aops_bit_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // Destination clock
  input wire logic rst_n, // Destination reset, active low
  input wire logic [WIDTH-1:0] d, // Level from the other domain
  output logic [WIDTH-1:0] q // Synchronised level
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] hold_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      hold_r <= '0;
    end else begin
      meta_r <= d;
      hold_r <= meta_r;
    end
  end

  assign q = hold_r;

endmodule

/* File: hw/aops_port_sequencer.sv */
// How it works
// - Sync input high in dual mode freezes data and clock outputs.
// - Interleaved: sample at first live edge N appears on A five edges later.
// - Interleaved: next sample appears on B five edges later, then alternating.
// - Parallel: port A delayed six edges, port B five, updating together.
// - After horizontal sync ends, first pixel reaches A five edges later when interleaved, six in parallel.
// - Sync tied low: sample taken with data clock low goes to A.
// - Single mode ignores the sync input entirely.
// - Single mode samples every edge, presents it at the fourth edge.
// - Single mode drives everything on A, port B holds still.
// - Single mode data clock runs at the conversion clock rate.
// - Dual modes data clock runs at half the conversion rate.
// - Dual modes data clock rises with every port B update.
`timescale 1ns/1ns
module aops_port_sequencer
  import aops_pkg::*;
#(
  parameter int DW = DATA_W,
  parameter int CH = NUM_CH
) (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic enc_clk, // Conversion clock, link side
  input wire logic [CH*DW-1:0] conv_data, // Converter results, enc_clk
  input wire logic port_align_sync_n, // Port sync, low = run
  input wire logic output_mode_select, // High = single channel
  input wire logic interleave_select, // Dual format, high = interleaved
  output logic [CH*DW-1:0] port_a_data, // Output port A
  output logic [CH*DW-1:0] port_b_data, // Output port B
  output logic output_data_clock, // Data clock output
  output logic output_data_clock_n, // Complement data clock
  output logic stat_frozen, // Outputs frozen, mclk level
  output logic stat_single_mode, // Single mode active, mclk level
  output logic stat_restart_pulse // Alignment restarted, mclk pulse
);

  // ---------------------------------------------------------------
  // Conversion clock reset
  // ---------------------------------------------------------------

  logic enc_rst_meta_r;
  logic enc_rst_sync_r;
  logic enc_rst_n;

  // Assert at once, release on the conversion clock so the
  // pipeline never leaves reset on a runt edge
  always_ff @(posedge enc_clk or negedge rst_n) begin
    if (!rst_n) begin
      enc_rst_meta_r <= 1'b0;
      enc_rst_sync_r <= 1'b0;
    end else begin
      enc_rst_meta_r <= 1'b1;
      enc_rst_sync_r <= enc_rst_meta_r;
    end
  end

  assign enc_rst_n = enc_rst_sync_r;

  // ---------------------------------------------------------------
  // System clock reset
  // ---------------------------------------------------------------

  logic sys_rst_meta_r;
  logic sys_rst_sync_r;
  logic sys_rst_n;

  // Same scheme on the system side: the pin reset may lift just
  // ahead of an mclk edge, so status flops leave reset in step
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sys_rst_meta_r <= 1'b0;
      sys_rst_sync_r <= 1'b0;
    end else begin
      sys_rst_meta_r <= 1'b1;
      sys_rst_sync_r <= sys_rst_meta_r;
    end
  end

  assign sys_rst_n = sys_rst_sync_r;

  // ---------------------------------------------------------------
  // Mode selection
  // ---------------------------------------------------------------

  logic [MODE_PIN_W-1:0] mode_pins_s;
  aops_mode_e mode;
  aops_mode_e mode_q_r;
  logic mode_change;
  logic single;

  // Mode straps are quasi-static pins, so a plain level crossing
  // is enough; a change flushes the pipeline below
  aops_bit_sync #(
    .WIDTH(MODE_PIN_W)
  ) u_mode_sync (
    .clk(enc_clk),
    .rst_n(enc_rst_n),
    .d({output_mode_select, interleave_select}),
    .q(mode_pins_s)
  );

  // Decode of the two mode pins
  always_comb begin
    if (mode_pins_s[PIN_OMS]) begin
      mode = MODE_SINGLE;
    end else if (mode_pins_s[PIN_ILV]) begin
      mode = MODE_INTERLEAVED;
    end else begin
      mode = MODE_PARALLEL;
    end
  end

  // Remember last mode to spot a change
  always_ff @(posedge enc_clk or negedge enc_rst_n) begin
    if (!enc_rst_n) begin
      mode_q_r <= MODE_PARALLEL;
    end else begin
      mode_q_r <= mode;
    end
  end

  assign mode_change = (mode != mode_q_r);
  assign single = (mode == MODE_SINGLE);

  // ---------------------------------------------------------------
  // Port alignment and freeze
  // ---------------------------------------------------------------

  logic live;
  logic restart_r;
  logic dclk_r;
  logic tag_now;
  logic advance;

  // The sync pin carries its own setup and hold against the
  // conversion edge, so it is sampled by this edge directly;
  // a two-stage crossing would move the port alignment
  always_comb begin
    live = single | ~port_align_sync_n;
    advance = live & ~mode_change;
  end

  // First live edge after a freeze always feeds port A; otherwise
  // the tag follows the data clock level held before the edge
  always_comb begin
    if (restart_r) begin
      tag_now = TAG_PORT_A;
    end else begin
      tag_now = dclk_r;
    end
  end

  // Restart marker: set by any frozen edge or mode change
  always_ff @(posedge enc_clk or negedge enc_rst_n) begin
    if (!enc_rst_n) begin
      restart_r <= RESTART_RST;
    end else if (!advance) begin
      restart_r <= 1'b1;
    end else begin
      restart_r <= 1'b0;
    end
  end

  // Half-rate data clock; held where it stands while frozen.
  // Leaving it high after an A sample makes it rise in step
  // with every port B update.
  always_ff @(posedge enc_clk or negedge enc_rst_n) begin
    if (!enc_rst_n) begin
      dclk_r <= DCLK_RST;
    end else if (advance && !single) begin
      dclk_r <= ~tag_now;
    end
  end

  // ---------------------------------------------------------------
  // Valid and tag pipeline
  // ---------------------------------------------------------------

  logic [PIPE_DEPTH-1:0] vpipe_r;
  logic [PIPE_DEPTH-1:0] tpipe_r;

  // Stage k holds the sample taken k edges ago. Samples taken
  // while frozen and anything still in flight are discarded,
  // so nothing stale leaks out after the freeze ends.
  always_ff @(posedge enc_clk or negedge enc_rst_n) begin
    if (!enc_rst_n) begin
      vpipe_r <= '0;
      tpipe_r <= '0;
    end else if (!advance) begin
      vpipe_r <= '0;
      tpipe_r <= '0;
    end else begin
      vpipe_r <= {vpipe_r[PIPE_DEPTH-2:0], 1'b1};
      tpipe_r <= {tpipe_r[PIPE_DEPTH-2:0], tag_now};
    end
  end

  // ---------------------------------------------------------------
  // Per-channel data path
  // ---------------------------------------------------------------

  // Update decisions shared by all channels
  logic load_a;
  logic load_b;
  int unsigned a_idx;

  always_comb begin
    load_a = 1'b0;
    load_b = 1'b0;
    a_idx = IDX_DUAL;
    case (mode)
      MODE_SINGLE: begin
        a_idx = IDX_SINGLE;
        load_a = vpipe_r[IDX_SINGLE];
      end
      MODE_INTERLEAVED: begin
        a_idx = IDX_DUAL;
        load_a = vpipe_r[IDX_DUAL] & (tpipe_r[IDX_DUAL] == TAG_PORT_A);
        load_b = vpipe_r[IDX_DUAL] & (tpipe_r[IDX_DUAL] == TAG_PORT_B);
      end
      MODE_PARALLEL: begin
        a_idx = IDX_PAR_A;
        load_a = vpipe_r[IDX_PAR_A] & (tpipe_r[IDX_PAR_A] == TAG_PORT_A);
        load_b = vpipe_r[IDX_DUAL] & (tpipe_r[IDX_DUAL] == TAG_PORT_B);
      end
      default: begin
        load_a = 1'b0;
        load_b = 1'b0;
      end
    endcase
  end

  for (genvar ch = 0; ch < CH; ch++) begin : g_ch
    logic [DW-1:0] dpipe_r [PIPE_DEPTH];
    logic [DW-1:0] a_r;
    logic [DW-1:0] b_r;

    // Data delay line; runs every edge, the valid bits decide use
    always_ff @(posedge enc_clk or negedge enc_rst_n) begin
      if (!enc_rst_n) begin
        for (int k = 0; k < PIPE_DEPTH; k++) begin
          dpipe_r[k] <= '0;
        end
      end else begin
        dpipe_r[0] <= conv_data[ch*DW +: DW];
        for (int k = 1; k < PIPE_DEPTH; k++) begin
          dpipe_r[k] <= dpipe_r[k-1];
        end
      end
    end

    // Port A register; holds whenever nothing is due
    always_ff @(posedge enc_clk or negedge enc_rst_n) begin
      if (!enc_rst_n) begin
        a_r <= '0;
      end else if (advance && load_a) begin
        a_r <= dpipe_r[a_idx];
      end
    end

    // Port B register; never loaded in single mode
    always_ff @(posedge enc_clk or negedge enc_rst_n) begin
      if (!enc_rst_n) begin
        b_r <= '0;
      end else if (advance && load_b) begin
        b_r <= dpipe_r[IDX_DUAL];
      end
    end

    assign port_a_data[ch*DW +: DW] = a_r;
    assign port_b_data[ch*DW +: DW] = b_r;
  end

  // ---------------------------------------------------------------
  // Data clock outputs
  // ---------------------------------------------------------------

  // Single mode needs a full-rate clock, which no flip-flop on
  // this clock can make, so the inverted conversion clock is
  // steered out; it rises mid-cycle, centred on stable port A
  // data. A mode change may leave one short pulse on the pin.
  always_comb begin
    if (single) begin
      output_data_clock = ~enc_clk;
    end else begin
      output_data_clock = dclk_r;
    end
    output_data_clock_n = ~output_data_clock;
  end

  // ---------------------------------------------------------------
  // Status towards the system clock
  // ---------------------------------------------------------------

  logic frozen_r;
  logic single_r;
  logic restart_tog_r;

  // Status levels and a restart toggle, all on the link clock
  always_ff @(posedge enc_clk or negedge enc_rst_n) begin
    if (!enc_rst_n) begin
      frozen_r <= 1'b0;
      single_r <= 1'b0;
      restart_tog_r <= 1'b0;
    end else begin
      frozen_r <= ~live;
      single_r <= single;
      if (advance && restart_r) begin
        restart_tog_r <= ~restart_tog_r;
      end
    end
  end

  logic [STAT_W-1:0] stat_s;
  logic tog_q_r;
  logic frozen_out_r;
  logic single_out_r;
  logic pulse_r;

  // A toggle survives the crossing where a one-cycle pulse might not
  aops_bit_sync #(
    .WIDTH(STAT_W)
  ) u_stat_sync (
    .clk(mclk),
    .rst_n(sys_rst_n),
    .d({restart_tog_r, single_r, frozen_r}),
    .q(stat_s)
  );

  // Registered status outputs and toggle edge detect
  always_ff @(posedge mclk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      tog_q_r <= 1'b0;
      frozen_out_r <= 1'b0;
      single_out_r <= 1'b0;
      pulse_r <= 1'b0;
    end else begin
      tog_q_r <= stat_s[STAT_TOGGLE];
      frozen_out_r <= stat_s[STAT_FROZEN];
      single_out_r <= stat_s[STAT_SINGLE];
      pulse_r <= stat_s[STAT_TOGGLE] ^ tog_q_r;
    end
  end

  assign stat_frozen = frozen_out_r;
  assign stat_single_mode = single_out_r;
  assign stat_restart_pulse = pulse_r;

endmodule

/* File: verif/aops_port_sequencer_chk.sv */
`timescale 1ns/1ns
module aops_port_sequencer_chk
  import aops_pkg::*;
#(
  parameter int DW = DATA_W,
  parameter int CH = NUM_CH
) (
  input wire logic rst_n, // Reset
  input wire logic enc_clk, // Link clock
  input wire logic [CH*DW-1:0] conv_data, // Samples
  input wire logic port_align_sync_n, // Sync pin
  input wire logic output_mode_select, // Mode pin
  input wire logic interleave_select, // Format pin
  input wire logic [CH*DW-1:0] port_a_data, // Port A
  input wire logic [CH*DW-1:0] port_b_data, // Port B
  input wire logic output_data_clock, // Data clock
  input wire logic output_data_clock_n // Its complement
);
  // ----------------
  // Steady-run counters
  // ----------------
  logic [3:0] scnt_r;
  logic [3:0] dcnt_r;
  logic ilv_r;

  // Checks wait out mode sync, flush and refill, which the counters span
  always_ff @(posedge enc_clk or negedge rst_n) begin
    if (!rst_n) begin
      scnt_r <= 4'h0;
      dcnt_r <= 4'h0;
      ilv_r <= 1'b0;
    end else begin
      ilv_r <= interleave_select;
      if (!output_mode_select) begin
        scnt_r <= 4'h0;
      end else if (scnt_r != 4'hf) begin
        scnt_r <= scnt_r + 4'h1;
      end
      if (output_mode_select || port_align_sync_n || interleave_select != ilv_r) begin
        dcnt_r <= 4'h0;
      end else if (dcnt_r != 4'hf) begin
        dcnt_r <= dcnt_r + 4'h1;
      end
    end
  end

  // ----------------
  // Properties
  // ----------------
  default clocking @(posedge enc_clk); endclocking
  default disable iff (!rst_n);

  sequence s_hold;
    !output_mode_select [*5] ##0 port_align_sync_n;
  endsequence
  sequence s_sgl;
    scnt_r >= 4'he;
  endsequence
  sequence s_ilv;
    dcnt_r >= 4'he ##0 interleave_select;
  endsequence
  sequence s_par;
    dcnt_r >= 4'he ##0 !interleave_select;
  endsequence

  property p_frz;
    s_hold |=> $stable(port_a_data) && $stable(port_b_data) && $stable(output_data_clock);
  endproperty
  property p_sgl_lat;
    s_sgl |-> port_a_data == $past(conv_data, 5);
  endproperty
  property p_sgl_b;
    s_sgl |-> $stable(port_b_data);
  endproperty
  property p_sgl_clk;
    @(negedge enc_clk) disable iff (!rst_n)
      scnt_r >= 4'he |-> !output_data_clock && output_data_clock_n;
  endproperty
  property p_half;
    dcnt_r >= 4'he |-> $changed(output_data_clock);
  endproperty
  property p_clk_b;
    dcnt_r >= 4'he |-> $rose(output_data_clock) == $changed(port_b_data);
  endproperty
  property p_ilv_alt;
    s_ilv |-> $changed(port_a_data) != $changed(port_b_data);
  endproperty
  property p_ilv_a;
    s_ilv ##0 !$past(output_data_clock, 6) |-> port_a_data == $past(conv_data, 6);
  endproperty
  property p_par_upd;
    s_par |-> $changed(port_a_data) == $changed(port_b_data);
  endproperty
  property p_par_dat;
    s_par ##0 $changed(port_b_data) |->
      port_a_data == $past(conv_data, 7) && port_b_data == $past(conv_data, 6);
  endproperty

  a_frz: assert property (p_frz) else $error("outputs moved while frozen");
  a_sgl_lat: assert property (p_sgl_lat) else $error("single latency wrong");
  a_sgl_b: assert property (p_sgl_b) else $error("port b moved in single");
  a_sgl_clk: assert property (p_sgl_clk) else $error("single data clock wrong");
  a_half: assert property (p_half) else $error("dual data clock stalled");
  a_clk_b: assert property (p_clk_b) else $error("clock rise not with port b");
  a_ilv_alt: assert property (p_ilv_alt) else $error("ports not alternating");
  a_ilv_a: assert property (p_ilv_a) else $error("low clock sample not on a");
  a_par_upd: assert property (p_par_upd) else $error("parallel ports apart");
  a_par_dat: assert property (p_par_dat) else $error("parallel latency wrong");
endmodule

/* File: verif/aops_cap_model.sv */
`timescale 1ns/1ns
// ----------------
// Capture side
// ----------------
module aops_cap_model #(
  parameter int W = 24
) (
  input wire logic output_data_clock, // Data clock
  input wire logic [W-1:0] port_a_data, // Port A
  input wire logic [W-1:0] port_b_data, // Port B
  output logic [W-1:0] cap_a, // Latched A
  output logic [W-1:0] cap_b // Latched B
);
  // Outside parallel format A moves as the clock falls, so take it on the rise, half a cycle clear
  always @(posedge output_data_clock) begin
    cap_a <= port_a_data;
  end
  // B moves as the clock rises, so take it on the fall
  always @(negedge output_data_clock) begin
    cap_b <= port_b_data;
  end
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  import aops_pkg::*;
  localparam int W = DATA_W * NUM_CH;
  logic mclk = 1'b0;
  logic enc_clk = 1'b0;
  logic rst_n = 1'b0;
  logic port_align_sync_n = 1'b0;
  logic output_mode_select = 1'b0;
  logic interleave_select = 1'b1;
  logic [W-1:0] conv_data, port_a_data, port_b_data, cap_a, cap_b;
  logic output_data_clock, output_data_clock_n, stat_frozen, stat_single_mode;
  logic stat_restart_pulse;
  logic [W-1:0] pulse_cnt = '0;
  int ecnt = 0;
  int err_total = 0;
  int check_count = 0;

  // ----------------
  // Clocks, source, helpers
  // ----------------
  initial begin
    forever #10 mclk = ~mclk;
  end
  // Offset start keeps the link clock out of step with the system clock
  initial begin
    #7;
    forever #32 enc_clk = ~enc_clk;
  end

  function automatic logic [W-1:0] dat(input int e);
    dat = {e[7:0] ^ 8'h5a, e[7:0] + 8'h11, e[7:0]};
  endfunction

  // Edge e samples dat(e), so expectations follow from the edge count
  always @(posedge enc_clk) begin
    ecnt = ecnt + 1;
    #2 conv_data = dat(ecnt + 1);
  end

  // Restart pulses seen on the system clock, one per restart
  always @(posedge mclk) begin
    if (stat_restart_pulse === 1'b1) pulse_cnt <= pulse_cnt + 1'b1;
  end

  task automatic edges(input int n);
    repeat (n) @(posedge enc_clk);
    #2;
  endtask

  task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Sync never driven: port follows the data clock level at sampling
  task automatic tied();
    int e;
    logic [1:0] lv;
    for (int i = 0; i < 2; i++) begin
      lv[i] = output_data_clock;
      edges(1);
    end
    chk(lv[1], !lv[0]);
    edges(4);
    e = ecnt - 5;
    for (int i = 0; i < 2; i++) begin
      chk(lv[i] ? port_b_data : port_a_data, dat(e + i));
      edges(1);
    end
    $display("tied sync done");
  endtask

  // Freeze for h+2 edges, then release; ilv names the dual format already set
  task automatic restart(input logic ilv, input int h);
    int n;
    logic [W-1:0] pa, pb, p0;
    logic dk;
    port_align_sync_n = 1'b1;
    edges(2);
    pa = port_a_data;
    pb = port_b_data;
    dk = output_data_clock;
    edges(h);
    chk(port_a_data, pa);
    chk(port_b_data, pb);
    chk(output_data_clock, dk);
    chk(stat_frozen, 1'b1);
    port_align_sync_n = 1'b0;
    n = ecnt + 1;
    p0 = pulse_cnt;
    edges(5);
    chk(port_a_data, pa);
    chk(pulse_cnt, p0 + 1'b1);
    chk(stat_frozen, 1'b0);
    edges(1);
    chk(port_a_data, ilv ? dat(n) : pa);
    edges(1);
    chk(port_b_data, dat(n + 1));
    chk(output_data_clock, 1'b1);
    if (!ilv) chk(port_a_data, dat(n));
    edges(1);
    if (ilv) chk(cap_a, dat(n));
    if (ilv) chk(cap_b, dat(n + 1));
    $display("restart format %0d done", ilv);
  endtask

  // Single mode with the sync pin toggling, which must change nothing
  task automatic single();
    int e;
    logic [W-1:0] pb;
    logic dk;
    output_mode_select = 1'b1;
    edges(16);
    pb = port_b_data;
    for (int i = 0; i < 6; i++) begin
      port_align_sync_n = ~port_align_sync_n;
      e = ecnt;
      edges(5);
      chk(port_a_data, dat(e + 1));
    end
    chk(port_b_data, pb);
    chk(stat_single_mode, 1'b1);
    // Full rate: the level flips every half conversion period
    @(negedge enc_clk);
    #2;
    dk = output_data_clock;
    edges(1);
    chk(output_data_clock, !dk);
    @(negedge enc_clk);
    #2;
    chk(output_data_clock, dk);
    $display("single mode done");
  endtask

  // ----------------
  // Main sequence
  // ----------------
  initial begin
    conv_data = dat(1);
    repeat (3) @(posedge enc_clk);
    #2 rst_n = 1'b1;
    edges(20);
    tied();
    restart(1'b1, 20);
    interleave_select = 1'b0;
    edges(8);
    restart(1'b0, 4);
    single();
    end_of_test();
  end

  // About thirty-six times the expected run length
  initial begin
    #300000;
    err_total++;
    end_of_test();
  end

  aops_port_sequencer #(.DW(DATA_W), .CH(NUM_CH)) u_aops_port_sequencer (
    .mclk(mclk), .rst_n(rst_n), .enc_clk(enc_clk), .conv_data(conv_data),
    .port_align_sync_n(port_align_sync_n), .output_mode_select(output_mode_select),
    .interleave_select(interleave_select), .port_a_data(port_a_data),
    .port_b_data(port_b_data), .output_data_clock(output_data_clock),
    .output_data_clock_n(output_data_clock_n), .stat_frozen(stat_frozen),
    .stat_single_mode(stat_single_mode), .stat_restart_pulse(stat_restart_pulse));

  aops_cap_model #(.W(W)) u_aops_cap_model (
    .output_data_clock(output_data_clock), .port_a_data(port_a_data),
    .port_b_data(port_b_data), .cap_a(cap_a), .cap_b(cap_b));
endmodule

bind aops_port_sequencer aops_port_sequencer_chk #(.DW(DW), .CH(CH)) u_chk (
  .rst_n(rst_n), .enc_clk(enc_clk), .conv_data(conv_data),
  .port_align_sync_n(port_align_sync_n), .output_mode_select(output_mode_select),
  .interleave_select(interleave_select), .port_a_data(port_a_data),
  .port_b_data(port_b_data), .output_data_clock(output_data_clock),
  .output_data_clock_n(output_data_clock_n));
